//--- src/srd_rx_clock_rate.sv
// SD recovered clock pattern, mode search and bit rate detect with APB registers
`timescale 1ns/1ps
`default_nettype none
module srd_rx_clock_rate
    import srd_pkg::*;
#(
    parameter int fixed_clock_hertz_param = FIXED_CLOCK_HERTZ_DEFAULT,
    parameter int rx_clock_hertz_param = RX_CLOCK_HERTZ_DEFAULT,
    parameter int search_dwell_cycles = SEARCH_DWELL_CYCLES,
    parameter bit expose_recovered_clock = 1'b0
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive side inputs
    input wire logic dru_strobe,
    input wire logic [9:0] rx_word_in,
    input wire logic rx_data_good,
    input wire logic fixed_clock,
    // Receive side outputs
    output logic [1:0] rx_mode,
    output logic rx_mode_locked,
    output logic rx_bit_rate,
    output logic sd_recovered_strobe,
    output logic [9:0] rx_word_out,
    output logic rx_word_ce,
    // Spare transmitter data word
    output logic [19:0] recovered_clock_txdata,
    // Interrupt
    output logic irq
);

    if (search_dwell_cycles < 2)
    begin : g_bad_dwell
        $error("search_dwell_cycles must be at least 2");
    end

    // Serialised pattern level for a bit position within the 270 MHz period
    function automatic logic [19:0] pattern_word(input logic [3:0] phase);
        int pos;
        logic [19:0] word;
        word = 20'h0;
        for (int i = 0; i < PATTERN_WORD_BITS; i++)
        begin
            pos = (int'(phase) + i) % PATTERN_PERIOD_BITS;
            word[i] = (pos < PATTERN_HIGH_BITS);
        end
        return word;
    endfunction : pattern_word

    // Phase after one word, plus an optional one bit slip
    function automatic logic [3:0] phase_step(input logic [3:0] phase, input int slip);
        int sum;
        sum = (int'(phase) + PATTERN_WORD_BITS + slip) % PATTERN_PERIOD_BITS;
        return 4'(sum);
    endfunction : phase_step

    // Register state
    logic [1:0] control;
    logic [INT_WIDTH-1:0] int_status;
    logic [INT_WIDTH-1:0] int_enable;

    // Mode search state
    srd_state_t state;
    srd_state_t next_state;
    logic [31:0] dwell_count;
    logic [1:0] next_mode;
    logic lock_gained;
    logic lock_lost;

    // Pattern generator state
    logic [3:0] phase;
    logic signed [11:0] phase_error;

    // Rate detector results
    logic [31:0] rate_count;
    logic det_bit_rate;
    logic det_done;

    // APB decode, one wait state per access
    wire access = psel & penable & ~pready;
    wire write_now = psel & penable & pready & pwrite;
    wire hit_control = (paddr == REG_CONTROL);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_int_status = (paddr == REG_INT_STATUS);
    wire hit_int_clear = (paddr == REG_INT_CLEAR);
    wire hit_int_enable = (paddr == REG_INT_ENABLE);
    wire hit_rate_count = (paddr == REG_RATE_COUNT);
    wire mapped = hit_control | hit_status | hit_int_status | hit_int_clear | hit_int_enable | hit_rate_count;
    wire search_enable = control[CTRL_SEARCH_EN_BIT];
    wire rate_enable = control[CTRL_RATE_EN_BIT];

    // Read data selection
    logic [31:0] read_value;
    always_comb
    begin
        read_value = 32'h0;
        if (hit_control)
            read_value = {30'h0, control};
        else if (hit_status)
            read_value = {28'h0, rx_bit_rate, rx_mode, rx_mode_locked};
        else if (hit_int_status)
            read_value = {28'h0, int_status};
        else if (hit_int_enable)
            read_value = {28'h0, int_enable};
        else if (hit_rate_count)
            read_value = rate_count;
    end

    // APB answer: pready one cycle after the access phase starts
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access;
            prdata <= (access && !pwrite) ? read_value : 32'h0;
            pslverr <= access & ~mapped;
        end
    end

    // Software registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            control <= CONTROL_RESET;
            int_enable <= INT_ENABLE_RESET;
        end
        else if (write_now)
        begin
            if (hit_control)
                control <= pwdata[1:0];
            if (hit_int_enable)
                int_enable <= pwdata[INT_WIDTH-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    wire rate_changed = det_done && (det_bit_rate != rx_bit_rate);
    wire [INT_WIDTH-1:0] events = {det_done, rate_changed, lock_lost, lock_gained};
    wire [INT_WIDTH-1:0] clear_mask = (write_now && hit_int_clear) ? pwdata[INT_WIDTH-1:0] : '0;
    wire [INT_WIDTH-1:0] next_int_status = (int_status & ~clear_mask) | events;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            int_status <= '0;
            irq <= 1'b0;
        end
        else
        begin
            int_status <= next_int_status;
            irq <= |(next_int_status & int_enable);
        end
    end

    // Mode search: dwell in each mode until valid data appears
    wire dwell_done = (dwell_count == 32'(search_dwell_cycles - 1));
    always_comb
    begin
        next_state = state;
        lock_gained = 1'b0;
        lock_lost = 1'b0;
        case (state)
            ST_SEARCH_SD:
            begin
                if (rx_data_good)
                begin
                    next_state = ST_LOCKED;
                    lock_gained = 1'b1;
                end
                else if (dwell_done && search_enable)
                    next_state = ST_SEARCH_HD;
            end
            ST_SEARCH_HD:
            begin
                if (rx_data_good)
                begin
                    next_state = ST_LOCKED;
                    lock_gained = 1'b1;
                end
                else if (dwell_done && search_enable)
                    next_state = ST_SEARCH_3G;
            end
            ST_SEARCH_3G:
            begin
                if (rx_data_good)
                begin
                    next_state = ST_LOCKED;
                    lock_gained = 1'b1;
                end
                else if (dwell_done && search_enable)
                    next_state = ST_SEARCH_SD;
            end
            ST_LOCKED:
            begin
                // Short dropouts are tolerated for one dwell period
                if (!rx_data_good && dwell_done)
                begin
                    next_state = ST_SEARCH_SD;
                    lock_lost = 1'b1;
                end
            end
            default:
                next_state = ST_SEARCH_SD;
        endcase
    end

    // Mode driven to the receiver follows the search state
    always_comb
    begin
        case (next_state)
            ST_SEARCH_HD:
                next_mode = MODE_HD;
            ST_SEARCH_3G:
                next_mode = MODE_3G;
            ST_LOCKED:
                next_mode = rx_mode;
            default:
                next_mode = MODE_SD;
        endcase
    end

    // Dwell counter restarts on any state change or good data while locked
    wire dwell_restart = (next_state != state) || (state == ST_LOCKED && rx_data_good);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_SEARCH_SD;
            dwell_count <= 32'h0;
            rx_mode <= MODE_SD;
            rx_mode_locked <= 1'b0;
        end
        else
        begin
            state <= next_state;
            dwell_count <= (dwell_restart || dwell_done) ? 32'h0 : dwell_count + 32'h1;
            rx_mode <= next_mode;
            rx_mode_locked <= (next_state == ST_LOCKED);
        end
    end

    // Downstream word register uses the strobe as an enable, not a clock
    wire sd_mode = (rx_mode == MODE_SD);
    wire word_enable = sd_mode ? dru_strobe : 1'b1;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_word_out <= 10'h0;
            rx_word_ce <= 1'b0;
            sd_recovered_strobe <= 1'b0;
        end
        else
        begin
            if (word_enable)
                rx_word_out <= rx_word_in;
            rx_word_ce <= word_enable;
            sd_recovered_strobe <= sd_mode & dru_strobe;
        end
    end

    // Phase error: pattern bits sent minus 110 per SD strobe
    // A slip of one bit at most per word keeps edge jitter to one bit time
    wire slip_late = (phase_error > 12'(PHASE_ERROR_LIMIT));
    wire slip_early = (phase_error < -12'(PHASE_ERROR_LIMIT));
    wire signed [11:0] slip = slip_late ? -12'sd1 : (slip_early ? 12'sd1 : 12'sd0);
    wire signed [11:0] strobe_bits = dru_strobe ? 12'(BITS_PER_SD_STROBE) : 12'sd0;
    wire signed [11:0] next_phase_error = phase_error + 12'(PATTERN_WORD_BITS) + slip - strobe_bits;

    // Pattern generator, free running at nominal rate outside SD mode
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase <= 4'h0;
            phase_error <= 12'sh0;
            recovered_clock_txdata <= 20'h0;
        end
        else
        begin
            if (sd_mode)
            begin
                phase <= phase_step(phase, int'(slip));
                phase_error <= next_phase_error;
            end
            else
            begin
                phase <= phase_step(phase, 0);
                phase_error <= 12'sh0;
            end
            // Bit 0 is serialised first
            recovered_clock_txdata <= expose_recovered_clock ? pattern_word(phase) : 20'h0;
        end
    end

    // Integer or fractional rate flag from the window measurement
    srd_rate_detect #(
        .fixed_clock_hertz_param(fixed_clock_hertz_param),
        .rx_clock_hertz_param(rx_clock_hertz_param)
    ) u_rate_detect (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(rate_enable),
        .fixed_clock(fixed_clock),
        .rate_count(rate_count),
        .bit_rate(det_bit_rate),
        .measure_done(det_done)
    );

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rx_bit_rate <= 1'b0;
        else if (det_done)
            rx_bit_rate <= det_bit_rate;
    end

endmodule : srd_rx_clock_rate
`default_nettype wire

//--- src/srd_pkg.sv
// Shared constants for the recovered clock and rate detect block
package srd_pkg;

    // Clock rate of sys_clk
    localparam int SYS_CLK_MHZ = 200;

    // Register byte offsets
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INT_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_CLEAR = 8'h0c;
    localparam logic [7:0] REG_INT_ENABLE = 8'h10;
    localparam logic [7:0] REG_RATE_COUNT = 8'h14;

    // Field positions
    localparam int CTRL_SEARCH_EN_BIT = 0;
    localparam int CTRL_RATE_EN_BIT = 1;
    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_MODE_LSB = 1;
    localparam int STAT_BIT_RATE_BIT = 3;
    localparam int INT_LOCK_GAINED = 0;
    localparam int INT_LOCK_LOST = 1;
    localparam int INT_RATE_CHANGED = 2;
    localparam int INT_MEASURE_DONE = 3;
    localparam int INT_WIDTH = 4;

    // Values after reset
    localparam logic [1:0] CONTROL_RESET = 2'h3;
    localparam logic [3:0] INT_ENABLE_RESET = 4'h0;

    // Receiver modes as reported on rx_mode
    localparam logic [1:0] MODE_HD = 2'h0;
    localparam logic [1:0] MODE_SD = 2'h1;
    localparam logic [1:0] MODE_3G = 2'h2;

    // Mode search dwell time per mode
    localparam int SEARCH_DWELL_US = 100;
    localparam int SEARCH_DWELL_CYCLES = SEARCH_DWELL_US * SYS_CLK_MHZ;

    // Recovered clock pattern: 11 serial bits per 270 MHz period, 20 bits per word
    localparam int PATTERN_PERIOD_BITS = 11;
    localparam int PATTERN_HIGH_BITS = 6;
    localparam int PATTERN_WORD_BITS = 20;
    localparam int BIT_TIME_PS = 337;
    localparam int BITS_PER_SD_STROBE = 110;
    localparam int PHASE_ERROR_LIMIT = 110;

    // Rate measurement window, timed by the fixed clock
    localparam int RATE_WINDOW_MS = 1;
    localparam int FIXED_CLOCK_HERTZ_DEFAULT = 27_000_000;
    localparam int RX_CLOCK_HERTZ_DEFAULT = 200_000_000;

    // Mode search states
    typedef enum logic [3:0]
    {
        ST_SEARCH_SD = 4'b0001,
        ST_SEARCH_HD = 4'b0010,
        ST_SEARCH_3G = 4'b0100,
        ST_LOCKED = 4'b1000
    } srd_state_t;

endpackage : srd_pkg

//--- src/srd_rate_detect.sv
// Integer or fractional bit rate detector timed by a fixed clock
`timescale 1ns/1ps
`default_nettype none
module srd_rate_detect
    import srd_pkg::*;
#(
    parameter int fixed_clock_hertz_param = FIXED_CLOCK_HERTZ_DEFAULT,
    parameter int rx_clock_hertz_param = RX_CLOCK_HERTZ_DEFAULT
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control
    input wire logic enable,
    input wire logic fixed_clock,
    // Results
    output logic [31:0] rate_count,
    output logic bit_rate,
    output logic measure_done
);

    localparam int WINDOW_EDGES = fixed_clock_hertz_param / 1000 * RATE_WINDOW_MS;
    localparam int NOMINAL_COUNT = rx_clock_hertz_param / 1000 * RATE_WINDOW_MS;
    // Halfway between 1/1 and 1/1.001 counts
    localparam int THRESHOLD = NOMINAL_COUNT - NOMINAL_COUNT / 2002;

    // Fixed clock must be sampled twice per period at least
    if (WINDOW_EDGES < 1 || fixed_clock_hertz_param * 2 > rx_clock_hertz_param)
    begin : g_bad_freq
        $error("fixed clock frequency unusable");
    end

    logic fixed_prev;
    logic [31:0] edge_count;
    logic [31:0] cycle_count;
    wire fixed_rise = fixed_clock & ~fixed_prev;
    wire window_end = fixed_rise && (edge_count == 32'(WINDOW_EDGES - 1));

    // Count receiver cycles across a window of fixed clock edges
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fixed_prev <= 1'b0;
            edge_count <= 32'h0;
            cycle_count <= 32'h0;
            rate_count <= 32'h0;
            bit_rate <= 1'b0;
            measure_done <= 1'b0;
        end
        else
        begin
            fixed_prev <= fixed_clock;
            measure_done <= 1'b0;
            if (!enable)
            begin
                edge_count <= 32'h0;
                cycle_count <= 32'h0;
            end
            else if (window_end)
            begin
                edge_count <= 32'h0;
                cycle_count <= 32'h0;
                rate_count <= cycle_count;
                bit_rate <= (cycle_count < 32'(THRESHOLD));
                measure_done <= 1'b1;
            end
            else
            begin
                edge_count <= edge_count + {31'h0, fixed_rise};
                cycle_count <= cycle_count + 32'h1;
            end
        end
    end

endmodule : srd_rate_detect
`default_nettype wire

//--- testbench/srd_rx_model.sv
// Receiver side model: recovery strobes, words, data-good flag and fixed clock
`timescale 1ns/1ps
`default_nettype none
module srd_rx_model
    import srd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench controls
    input wire logic [1:0] rx_mode,
    input wire logic [1:0] want_mode,
    input wire logic good_en,
    input wire logic [7:0] fx_half,
    // Towards the block
    output logic dru_strobe,
    output logic [9:0] rx_word_in,
    output logic rx_data_good,
    output logic fixed_clock
);
    logic [2:0] gap;
    logic odd;
    logic [7:0] fx_cnt;
    logic fx_wrap;

    assign fx_wrap = fx_cnt >= fx_half - 8'h01;

    // Strobe every 5 or 6 cycles; word toggles between strobes so stale loads show
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap <= 3'h5;
            odd <= 1'b0;
            dru_strobe <= 1'b0;
            rx_word_in <= 10'h000;
        end
        else
        begin
            dru_strobe <= gap == 3'h0;
            gap <= (gap == 3'h0) ? (odd ? 3'h4 : 3'h5) : gap - 3'h1;
            odd <= (gap == 3'h0) ? ~odd : odd;
            rx_word_in <= (gap == 3'h0) ? rx_word_in + 10'h025 : ~rx_word_in;
        end
    end

    // Data valid follows the mode now applied, so a search step cannot lock the old mode
    assign rx_data_good = good_en && rx_mode == want_mode;

    // Fixed clock always runs
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fx_cnt <= 8'h00;
            fixed_clock <= 1'b0;
        end
        else
        begin
            fx_cnt <= fx_wrap ? 8'h00 : fx_cnt + 8'h01;
            fixed_clock <= fx_wrap ? ~fixed_clock : fixed_clock;
        end
    end
endmodule : srd_rx_model
`default_nettype wire

//--- testbench/srd_rx_clock_rate_asserts.sv
// Concurrent checks on the ports of the recovered clock and rate block
`timescale 1ns/1ps
`default_nettype none
module srd_rx_clock_rate_asserts
    import srd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Receive side
    input wire logic dru_strobe,
    input wire logic [9:0] rx_word_in,
    input wire logic rx_data_good,
    input wire logic [1:0] rx_mode,
    input wire logic rx_mode_locked,
    input wire logic sd_recovered_strobe,
    input wire logic [9:0] rx_word_out,
    input wire logic rx_word_ce
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Strobe taken while SD mode holds over the cycle
    sequence s_sd_strobe;
        dru_strobe && rx_mode == MODE_SD ##1 rx_mode == MODE_SD;
    endsequence
    // Mode step while unlocked in both cycles
    sequence s_search_step;
        !rx_mode_locked && !$past(rx_mode_locked) && rx_mode != $past(rx_mode);
    endsequence

    a_strobe_follow: assert property (s_sd_strobe |-> sd_recovered_strobe)
        else $error("sd strobe did not follow the recovery strobe");
    a_strobe_cause: assert property (sd_recovered_strobe |-> $past(dru_strobe))
        else $error("sd strobe without a recovery strobe");
    a_word_load: assert property (rx_word_ce |-> rx_word_out == $past(rx_word_in))
        else $error("word out not loaded with the strobed word");
    a_ce_sd_only: assert property (rx_mode == MODE_SD && $past(rx_mode) == MODE_SD |-> rx_word_ce == sd_recovered_strobe)
        else $error("datapath enable differs from sd strobe");
    a_lock_gain: assert property (!rx_mode_locked && rx_data_good |-> ##[1:2] rx_mode_locked)
        else $error("valid data did not lock");
    a_mode_hold: assert property (rx_mode_locked && $past(rx_mode_locked) |-> $stable(rx_mode))
        else $error("mode moved while locked");
    a_step_order: assert property (s_search_step |->
        rx_mode == ($past(rx_mode) == MODE_SD ? MODE_HD : $past(rx_mode) == MODE_HD ? MODE_3G : MODE_SD))
        else $error("search left the sd hd 3g order");
    a_dwell_hold: assert property (s_search_step |=> $stable(rx_mode)[*4])
        else $error("search step came too soon");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
endmodule : srd_rx_clock_rate_asserts

bind srd_rx_clock_rate srd_rx_clock_rate_asserts i_asserts
(
    .sys_clk, .reset_n, .psel, .penable, .pready, .dru_strobe, .rx_word_in, .rx_data_good,
    .rx_mode, .rx_mode_locked, .sd_recovered_strobe, .rx_word_out, .rx_word_ce
);
`default_nettype wire

//--- testbench/test_srd_rx_clock_rate.sv
// Self-checking bench for the recovered clock and rate detect block
`timescale 1ns/1ps
`default_nettype none
module test_srd_rx_clock_rate
    import srd_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, dru_strobe, rx_data_good, fixed_clock, irq;
    logic rx_mode_locked, rx_bit_rate, sd_recovered_strobe, rx_word_ce, e, last;
    logic [9:0] rx_word_in, rx_word_out;
    logic [1:0] rx_mode, m;
    logic [1:0] want_mode = MODE_3G;
    logic good_en = 1'b0;
    logic tally = 1'b0;
    logic [7:0] fx_half = 8'h0b;
    logic [19:0] recovered_clock_txdata;
    logic [31:0] q;
    int bad_count = 0, cmp_count = 0, edges = 0, strobes = 0, run = 0, gap = 0;

    always #2.5 sys_clk = ~sys_clk;

    // Scaled counts keep one rate window near 2000 cycles
    srd_rx_clock_rate #(.fixed_clock_hertz_param(100000), .rx_clock_hertz_param(2000000),
        .search_dwell_cycles(8), .expose_recovered_clock(1'b1)) i_dut
    (
        .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .dru_strobe, .rx_word_in, .rx_data_good, .fixed_clock, .rx_mode, .rx_mode_locked, .rx_bit_rate,
        .sd_recovered_strobe, .rx_word_out, .rx_word_ce, .recovered_clock_txdata, .irq
    );

    srd_rx_model i_model
    (
        .sys_clk, .reset_n, .rx_mode, .want_mode, .good_en, .fx_half, .dru_strobe, .rx_word_in,
        .rx_data_good, .fixed_clock
    );

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Request stands until the rising edge that samples pready high
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1)
            chk("apb ready", 32'h1, 32'h0);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for lock (k=0) or irq (k=1) to reach level v
    task automatic wt(input bit k, input logic v);
        int n;
        n = 0;
        do @(posedge sys_clk); while (((k ? irq : rx_mode_locked) !== v) && ++n < 8000);
        if (n >= 8000)
            chk(k ? "irq wait" : "lock wait", v, ~v);
    endtask : wt

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // Serialise the pattern bit 0 first, as a 20-bit spare transmitter on sys_clk would
    always @(posedge sys_clk)
    begin
        if (tally)
        begin
            for (int i = 0; i < 20; i++)
            begin
                run++;
                if (recovered_clock_txdata[i] && !last)
                begin
                    if (edges > 0)
                        chk("edge spacing", 1, run >= 10 && run <= 12);
                    edges++;
                    run = 0;
                end
                last = recovered_clock_txdata[i];
            end
            gap++;
            if (sd_recovered_strobe)
            begin
                if (strobes > 0)
                    chk("strobe gap", 1, gap == 5 || gap == 6);
                strobes++;
                gap = 0;
            end
        end
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        chk("mode after reset", MODE_SD, rx_mode);
        apb(1'b0, REG_CONTROL, 32'h0);
        chk("control reset", 32'h3, q);
        apb(1'b0, REG_INT_ENABLE, 32'h0);
        chk("int enable reset", 32'h0, q);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped error", 1, e);
        $display("test registers done");
        // Search until the model's mode gives valid data
        apb(1'b1, REG_INT_ENABLE, 32'h1);
        good_en <= 1'b1;
        wt(1'b0, 1'b1);
        chk("locked mode", MODE_3G, rx_mode);
        wt(1'b1, 1'b1);
        apb(1'b1, REG_STATUS, 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status locked", 32'h5, q);
        apb(1'b1, REG_INT_CLEAR, 32'h1);
        wt(1'b1, 1'b0);
        good_en <= 1'b0;
        wt(1'b0, 1'b0);
        chk("unlocked mode", MODE_SD, rx_mode);
        apb(1'b0, REG_INT_STATUS, 32'h0);
        chk("lock events", 32'h2, {30'h0, q[1:0]});
        chk("masked irq", 0, irq);
        $display("test lock done");
        // Search disabled freezes the mode
        apb(1'b1, REG_CONTROL, 32'h2);
        // A dwell step may land on the write edge itself; take the mode after it
        @(posedge sys_clk);
        m = rx_mode;
        repeat (40) @(posedge sys_clk);
        chk("search frozen", m, rx_mode);
        want_mode <= MODE_SD;
        good_en <= 1'b1;
        apb(1'b1, REG_CONTROL, 32'h3);
        wt(1'b0, 1'b1);
        chk("sd lock", MODE_SD, rx_mode);
        $display("test search done");
        // Pattern edges track the strobe rate, 10 periods per strobe
        tally <= 1'b1;
        repeat (1100) @(posedge sys_clk);
        tally <= 1'b0;
        chk("edge rate", 1, edges >= strobes * 10 - 3 && edges <= strobes * 10 + 3);
        chk("strobe count", 1, strobes >= 195 && strobes <= 201);
        $display("test sd done");
        // Integer then fractional rate, one clean window each
        apb(1'b1, REG_INT_ENABLE, 32'h8);
        for (int k = 0; k < 2; k++)
        begin
            fx_half <= k ? 8'h09 : 8'h0b;
            repeat (2)
            begin
                apb(1'b1, REG_INT_CLEAR, 32'hf);
                wt(1'b1, 1'b1);
            end
            apb(1'b0, REG_RATE_COUNT, 32'h0);
            chk("rate count", 1, q >= (k ? 1790 : 2190) && q <= (k ? 1810 : 2210));
            chk("bit rate", k, rx_bit_rate);
        end
        $display("test rate done");
        results();
    end

    // Whole run is near 8000 cycles
    initial
    begin
        #300000;
        bad_count++;
        results();
    end
endmodule : test_srd_rx_clock_rate
`default_nettype wire
